// File: logic/lowpower_timer_event_flags.v
// Event and wakeup flags of the low-power timer with an AXI4-Lite register slave
`timescale 1ns/100ps
`include "timer_event_flags_defs.vh"

module lowpower_timer_event_flags #(
	parameter ADDR_W = 12
) (
	input wire core_clk,
	input wire rst,
	input wire cnt_eq_cmp,
	input wire cnt_wrap,
	input wire rep_zero,
	input wire trig_edge,
	input wire timer_running,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg irq,
	output reg wakeup
);

	// Expand byte strobes to a bit mask
	function [31:0] strb_mask;
		input [3:0] strb;
		begin
			strb_mask = {
				{8{strb[3]}},
				{8{strb[2]}},
				{8{strb[1]}},
				{8{strb[0]}}
			};
		end
	endfunction

	// Word offset compare, ignoring the two byte-select bits
	function addr_hit;
		input [ADDR_W-1:0] addr;
		input [11:0] ofs;
		begin
			addr_hit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
		end
	endfunction

	// Flag update where a same-cycle set beats a clear
	function flag_next;
		input cur;
		input set;
		input clr;
		begin
			flag_next = set | (cur & ~clr);
		end
	endfunction

	// Write channel holding registers
	reg aw_held_q;
	reg [ADDR_W-1:0] aw_addr_q;
	reg w_held_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;

	// Flag and enable storage
	reg upd_flag_q;
	reg ovf_flag_q;
	reg cmp_flag_q;
	reg trg_flag_q;
	reg upd_wake_q;
	reg ovf_wake_q;
	reg cmp_wake_q;
	reg [31:0] enable_q;
	reg cmp_prev_q;

	wire [31:0] status_word;
	wire [31:0] enable_word;
	wire wr_fire;
	wire [31:0] wr_mask;
	wire clear_hit;
	wire enable_hit;
	wire status_hit;
	wire [31:0] clr_bits;
	wire cmp_rise;
	wire trg_set;
	wire upd_set;
	wire ovf_set;
	reg [31:0] rd_data;
	reg [1:0] rd_resp;

	// Accept each write channel independently; stall once one is held
	assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;

	// Read address taken only when no read answer is pending
	assign s_axi_arready = ~s_axi_rvalid;

	assign wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;
	assign wr_mask = w_data_q & strb_mask(w_strb_q);
	assign clear_hit = addr_hit(aw_addr_q, `TEF_CLEAR_OFS);
	assign enable_hit = addr_hit(aw_addr_q, `TEF_ENABLE_OFS);
	assign status_hit = addr_hit(aw_addr_q, `TEF_STATUS_OFS);

	// Only ones in enabled byte lanes clear; zeros leave flags alone
	assign clr_bits = (wr_fire & clear_hit) ? wr_mask : 32'h00000000;

	// Equality is a level; flag on its rising edge only
	assign cmp_rise = cnt_eq_cmp & ~cmp_prev_q;

	// Edges arriving while running are dropped by the trigger logic
	assign trg_set = trig_edge & ~timer_running;

	assign upd_set = cnt_wrap & rep_zero;

	// Each high cycle of the wrap pulse is one overflow
	assign ovf_set = cnt_wrap;

	// Reserved bits [7:4] and upper bits read zero
	assign status_word = {
		21'h000000,
		cmp_wake_q,
		ovf_wake_q,
		upd_wake_q,
		4'h0,
		trg_flag_q,
		cmp_flag_q,
		ovf_flag_q,
		upd_flag_q
	};

	assign enable_word = enable_q & (`TEF_EVENT_MASK | `TEF_WAKE_MASK);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= {ADDR_W{1'b0}};
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_q <= 1'b0;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			w_held_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_q <= 1'b0;
		end
	end

	// Write response: status is read-only, so a write there is an error
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_axi_bresp <= `TEF_RESP_OKAY;
		end else if (wr_fire) begin
			if (clear_hit || enable_hit) begin
				s_axi_bresp <= `TEF_RESP_OKAY;
			end else begin
				s_axi_bresp <= `TEF_RESP_SLVERR;
			end
		end
	end

	// Enable register steers both the interrupt and the wakeup flags
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			enable_q <= `TEF_ENABLE_RESET;
		end else if (wr_fire && enable_hit) begin
			enable_q <= (enable_q & ~strb_mask(w_strb_q)) | wr_mask;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cmp_prev_q <= 1'b0;
		end else begin
			cmp_prev_q <= cnt_eq_cmp;
		end
	end

	// Update needs both a wrap and an exhausted repetition count
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			upd_flag_q <= 1'b0;
		end else begin
			upd_flag_q <= flag_next(upd_flag_q, upd_set,
				clr_bits[`TEF_UPDATE_BIT]);
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ovf_flag_q <= 1'b0;
		end else begin
			ovf_flag_q <= flag_next(ovf_flag_q, ovf_set,
				clr_bits[`TEF_OVERFLOW_BIT]);
		end
	end

	// A compare held equal sets the flag once, not every cycle
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cmp_flag_q <= 1'b0;
		end else begin
			cmp_flag_q <= flag_next(cmp_flag_q, cmp_rise,
				clr_bits[`TEF_COMPARE_BIT]);
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			trg_flag_q <= 1'b0;
		end else begin
			trg_flag_q <= flag_next(trg_flag_q, trg_set,
				clr_bits[`TEF_TRIGGER_BIT]);
		end
	end

	// Wakeup flags follow events only while their wakeup enable is set.
	// Software drops the enable first, so a clear is not undone at once.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			upd_wake_q <= 1'b0;
		end else begin
			upd_wake_q <= flag_next(upd_wake_q,
				upd_set & enable_q[`TEF_UPD_WAKE_BIT],
				clr_bits[`TEF_WAKE_CLEAR_BIT]);
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ovf_wake_q <= 1'b0;
		end else begin
			ovf_wake_q <= flag_next(ovf_wake_q,
				ovf_set & enable_q[`TEF_OVF_WAKE_BIT],
				clr_bits[`TEF_WAKE_CLEAR_BIT]);
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cmp_wake_q <= 1'b0;
		end else begin
			cmp_wake_q <= flag_next(cmp_wake_q,
				cmp_rise & enable_q[`TEF_CMP_WAKE_BIT],
				clr_bits[`TEF_WAKE_CLEAR_BIT]);
		end
	end

	// Interrupt and wakeup outputs, registered to avoid glitches
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_word & enable_word & `TEF_EVENT_MASK);
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wakeup <= 1'b0;
		end else begin
			wakeup <= |(status_word & `TEF_WAKE_MASK);
		end
	end

	// Read decode; clear register is write-only and reads zero
	always @* begin
		rd_data = 32'h00000000;
		rd_resp = `TEF_RESP_OKAY;
		if (addr_hit(s_axi_araddr, `TEF_STATUS_OFS)) begin
			rd_data = status_word;
		end else if (addr_hit(s_axi_araddr, `TEF_ENABLE_OFS)) begin
			rd_data = enable_word;
		end else if (addr_hit(s_axi_araddr, `TEF_CLEAR_OFS)) begin
			rd_data = 32'h00000000;
		end else begin
			rd_resp = `TEF_RESP_SLVERR;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Read data is captured once and holds until the next accepted address
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `TEF_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_resp;
		end
	end

endmodule // lowpower_timer_event_flags

// File: logic/timer_event_flags_defs.vh
// Register map and field positions of the timer event flag block
`ifndef TIMER_EVENT_FLAGS_DEFS_VH
`define TIMER_EVENT_FLAGS_DEFS_VH

// Byte addresses on the register bus
`define TEF_STATUS_OFS 12'h000
`define TEF_CLEAR_OFS 12'h004
`define TEF_ENABLE_OFS 12'h008

// Status, clear and enable bit positions (shared layout, but clear bit 8 clears all three wake flags)
`define TEF_UPDATE_BIT 0
`define TEF_OVERFLOW_BIT 1
`define TEF_COMPARE_BIT 2
`define TEF_TRIGGER_BIT 3
`define TEF_UPD_WAKE_BIT 8
`define TEF_OVF_WAKE_BIT 9
`define TEF_CMP_WAKE_BIT 10
`define TEF_WAKE_CLEAR_BIT 8

// Implemented bits
`define TEF_EVENT_MASK 32'h0000000F
`define TEF_WAKE_MASK 32'h00000700
`define TEF_STATUS_RESET 32'h00000000
`define TEF_ENABLE_RESET 32'h00000000

// Bus responses
`define TEF_RESP_OKAY 2'h0
`define TEF_RESP_SLVERR 2'h2

`endif

// File: verification/lowpower_timer_event_flags_sva.sv
// Bound assertion checker for the timer event flag block
`timescale 1ns/100ps
`include "timer_event_flags_defs.vh"
module tef_checker #(
	parameter ADDR_W = 12
) (
	input wire core_clk,
	input wire rst,
	input wire cnt_eq_cmp,
	input wire cnt_wrap,
	input wire rep_zero,
	input wire trig_edge,
	input wire timer_running,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire wakeup
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	wire wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	reg eq_q;
	reg [3:0] clr_q;
	// Flags known cleared since the last clear write or reset
	wire [3:0] ev = {trig_edge && !timer_running, cnt_eq_cmp && !eq_q, cnt_wrap,
		cnt_wrap && rep_zero};
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			eq_q <= 1'b0;
			clr_q <= 4'hF;
		end else begin
			eq_q <= cnt_eq_cmp;
			if (wt && s_axi_awaddr == `TEF_CLEAR_OFS && s_axi_wstrb[0])
				clr_q <= (clr_q | s_axi_wdata[3:0]) & ~ev;
			else
				clr_q <= clr_q & ~ev;
		end
	end
	sequence st_rd;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `TEF_STATUS_OFS;
	endsequence
	trig_set_a: assert property (trig_edge && !timer_running ##1 st_rd |=> s_axi_rdata[3])
		else $error("trigger flag not set");
	cmp_set_a: assert property ($rose(cnt_eq_cmp) ##1 st_rd |=> s_axi_rdata[2])
		else $error("compare flag not set");
	ovf_set_a: assert property (cnt_wrap ##1 st_rd |=> s_axi_rdata[1])
		else $error("overflow flag not set");
	upd_set_a: assert property (cnt_wrap && rep_zero ##1 st_rd |=> s_axi_rdata[0])
		else $error("update flag not set");
	resv_zero_a: assert property (st_rd |=> s_axi_rdata[7:4] == 4'h0)
		else $error("reserved status bits set");
	clear_effect_a: assert property (st_rd |=> (s_axi_rdata[3:0] & $past(clr_q)) == 4'h0)
		else $error("cleared flag still set");
	status_ro_a: assert property (wt && s_axi_awaddr == `TEF_STATUS_OFS
		|=> ##1 s_axi_bvalid && s_axi_bresp == `TEF_RESP_SLVERR)
		else $error("status write not refused");
	wake_clear_a: assert property ((wt && s_axi_awaddr == `TEF_CLEAR_OFS && s_axi_wdata[8]
		&& s_axi_wstrb[1]) ##1 (!cnt_wrap && !cnt_eq_cmp)[*2] |=> !wakeup)
		else $error("wakeup not cleared");
endmodule // tef_checker

bind lowpower_timer_event_flags tef_checker #(.ADDR_W(ADDR_W)) u_tef_checker (.core_clk,
	.rst, .cnt_eq_cmp, .cnt_wrap, .rep_zero, .trig_edge, .timer_running, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.wakeup);

// File: verification/testbench.sv
// Testbench for the timer event flag block
`timescale 1ns/100ps
module testbench;
	reg core_clk = 1'b0;
	reg rst = 1'b1;
	reg cnt_eq_cmp = 1'b0, cnt_wrap = 1'b0, rep_zero = 1'b0, trig_edge = 1'b0;
	reg timer_running = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	reg [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	reg [31:0] s_axi_wdata = 32'h00000000;
	reg [3:0] s_axi_wstrb = 4'hF;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, wakeup;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	integer num_errors = 0, checks = 0, cyc = 0;
	lowpower_timer_event_flags u_lowpower_timer_event_flags (.core_clk, .rst, .cnt_eq_cmp,
		.cnt_wrap, .rep_zero, .trig_edge, .timer_running, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .wakeup);
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("BAD %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// Ready is driven high on every call and never dropped, so it stays high between back-to-back calls
	task wr(input [11:0] a, input [31:0] d, input [1:0] r);
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			do begin
				@(posedge core_clk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
			end while (!s_axi_bvalid);
			chk(s_axi_bresp, r);
		end
	endtask
	task rc(input [11:0] a, input [31:0] e, input [1:0] r);
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do begin
				@(posedge core_clk);
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
			end while (!s_axi_rvalid);
			chk(s_axi_rdata, e);
			chk(s_axi_rresp, r);
		end
	endtask
	task ev(input t, input w, input z);
		begin
			trig_edge <= t;
			cnt_wrap <= w;
			rep_zero <= z;
			@(posedge core_clk);
			trig_edge <= 1'b0;
			cnt_wrap <= 1'b0;
		end
	endtask
	task t_bus;
		begin
			rc(12'h000, 32'h0, 2'h0);
			wr(12'h000, 32'hFFFFFFFF, 2'h2);
			rc(12'h000, 32'h0, 2'h0);
			rc(12'h004, 32'h0, 2'h0);
			rc(12'h00C, 32'h0, 2'h2);
			$display("t_bus done");
		end
	endtask
	task t_trig;
		begin
			timer_running <= 1'b1;
			ev(1'b1, 1'b0, 1'b0);
			rc(12'h000, 32'h0, 2'h0);
			timer_running <= 1'b0;
			ev(1'b1, 1'b0, 1'b0);
			rc(12'h000, 32'h8, 2'h0);
			wr(12'h004, 32'h0, 2'h0);
			rc(12'h000, 32'h8, 2'h0);
			wr(12'h004, 32'h8, 2'h0);
			rc(12'h000, 32'h0, 2'h0);
			$display("t_trig done");
		end
	endtask
	task t_cnt;
		begin
			cnt_eq_cmp <= 1'b1;
			@(posedge core_clk);
			rc(12'h000, 32'h4, 2'h0);
			cnt_eq_cmp <= 1'b0;
			ev(1'b0, 1'b1, 1'b0);
			rc(12'h000, 32'h6, 2'h0);
			ev(1'b0, 1'b1, 1'b1);
			rc(12'h000, 32'h7, 2'h0);
			wr(12'h004, 32'h2, 2'h0);
			rc(12'h000, 32'h5, 2'h0);
			wr(12'h004, 32'h4, 2'h0);
			rc(12'h000, 32'h1, 2'h0);
			wr(12'h004, 32'h1, 2'h0);
			rc(12'h000, 32'h0, 2'h0);
			$display("t_cnt done");
		end
	endtask
	task t_irq;
		begin
			wr(12'h008, 32'h101, 2'h0);
			rc(12'h008, 32'h101, 2'h0);
			ev(1'b0, 1'b1, 1'b1);
			rc(12'h000, 32'h103, 2'h0);
			chk(irq, 32'h1);
			chk(wakeup, 32'h1);
			wr(12'h008, 32'h100, 2'h0);
			rc(12'h000, 32'h103, 2'h0);
			chk(irq, 32'h0);
			// Enable dropped first, else a new event re-sets the wakeup flag
			wr(12'h008, 32'h0, 2'h0);
			wr(12'h004, 32'h103, 2'h0);
			rc(12'h000, 32'h0, 2'h0);
			chk(wakeup, 32'h0);
			$display("t_irq done");
		end
	endtask
	task t_wake;
		begin
			wr(12'h008, 32'h600, 2'h0);
			rc(12'h008, 32'h600, 2'h0);
			cnt_eq_cmp <= 1'b1;
			ev(1'b0, 1'b1, 1'b0);
			cnt_eq_cmp <= 1'b0;
			rc(12'h000, 32'h606, 2'h0);
			chk(wakeup, 32'h1);
			chk(irq, 32'h0);
			wr(12'h008, 32'h0, 2'h0);
			s_axi_wstrb <= 4'h1;
			wr(12'h004, 32'h106, 2'h0);
			s_axi_wstrb <= 4'hF;
			rc(12'h000, 32'h600, 2'h0);
			chk(wakeup, 32'h1);
			wr(12'h004, 32'h100, 2'h0);
			rc(12'h000, 32'h0, 2'h0);
			chk(wakeup, 32'h0);
			$display("t_wake done");
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d errors %0d", checks, num_errors);
			if (num_errors == 0 && checks > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			num_errors = num_errors + 1;
			stop_test;
		end
	end
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		t_bus;
		t_trig;
		t_cnt;
		t_irq;
		t_wake;
		stop_test;
	end
endmodule // testbench
